// ---- src/lcddc_top.sv ----
// Segment LCD drive control: registers on AHB-Lite, frame scan, drive levels, charge pulse
// How it works
// - Bit 7 selects A or B waveform
// - Bits 6,5 read one, writes ignored
// - Bit 4 reads zero; software writes zero
// - lcd_control_two resets to 60 hex
// - Pulse duty field decodes eighths, sixteenth, thirty-second
// - Split resistance connected during charge part
// - Zero-duty code keeps resistance always disconnected
// - Standby bit zero halts block; resets one
// - Boost copies commons in static, half duty
// - Four duties: static, half, third, quarter
// - Only selected segment drivers are enabled
// - Display memory takes byte and word writes
// - Memory mapping depends on duty, expansion; here only expansion and the scanned common pick the row
// - Activate clear halts and forces supply off
// - Data control zero shows blank segments
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module lcddc_top
    import lcddc_pkg::*;
#(
    parameter int NSEG    = 32,  // Segment outputs, at most 32
    parameter int W_SHIFT = 4    // Divider exponent that stands in for the subclock
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata,
    output logic      [3:0][1:0]       com_lvl,
    output logic      [NSEG-1:0][1:0]  seg_lvl,
    output logic      [NSEG-1:0]       seg_oe,
    output logic                       split_conn,
    output logic                       supply_on
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    lcddc_bus_e  bus_q, bus_d;            // Data phase state
    lcddc_req_s  req_q, req_d;            // Captured address phase
    logic        pend_q, pend_d;          // Captured phase awaiting its data phase
    logic [31:0] hrdata_d;
    logic        hready_d;
    lcddc_mode_s mode_q, mode_d;
    lcddc_ctrl_s ctrl_q, ctrl_d;
    logic        wave_q, wave_d;          // waveform_select
    logic [3:0]  cds_q, cds_d;            // pulse_duty_field
    logic [3:0]  ckstp_q, ckstp_d;        // Writable low nibble of clock_stop_two
    logic        wr_commit;               // Write data phase completes this edge
    logic        ctl2_wr;                 // lcd_control_two rewritten this edge
    logic [3:0]  ram_we;
    logic [31:0] ram_rdata, row_q;        // Bus read word, scanned common row
    logic        running;                 // Activated and out of standby
    logic [3:0]  shift;
    logic [8:0]  div_q, div_d, limit;
    logic        tick;                    // One operating clock step
    logic [1:0]  com_q, com_d;            // Scanned common
    logic        m_q, m_d;                // Alternation phase
    logic        last;                    // Scan sits on its last common
    logic [4:0]  pcnt_q, pcnt_d, per, chg;
    logic        pulse_hi;
    logic        supply_d, split_d;
    logic [3:0][1:0]      com_d_lvl;
    logic [NSEG-1:0][1:0] seg_d_lvl;
    logic [NSEG-1:0]      seg_oe_d;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: writes finish in their data phase, reads take two wait states
    // so that a read right after a write sees the written value
    assign wr_commit = (bus_q == BUS_IDLE) && pend_q && req_q.wr;
    assign ctl2_wr   = wr_commit && !req_q.ram && req_q.addr == OFS_CTL2 && req_q.be[0];
    assign ram_we    = (wr_commit && req_q.ram) ? req_q.be : 4'h0;

    always_comb begin
        bus_d    = bus_q;
        req_d    = req_q;
        pend_d   = pend_q;
        hrdata_d = hrdata;
        hready_d = hreadyout;
        if (bus_q == BUS_IDLE) begin
            pend_d = 1'b0;
            // Address phase taken only when the bus is ready
            if (hsel && hready && htrans[1]) begin
                pend_d     = 1'b1;
                req_d.wr   = hwrite;
                req_d.ram  = haddr[7:5] == RAM_SEL;
                req_d.addr = haddr[7:0];
                unique case (hsize)
                    HSIZE_BYTE: req_d.be = 4'h1 << haddr[1:0];
                    HSIZE_HALF: req_d.be = haddr[1] ? 4'hc : 4'h3;
                    default:    req_d.be = 4'hf;
                endcase
                if (!hwrite) begin
                    bus_d    = BUS_RD1;
                    hready_d = 1'b0;
                end
            end
        end else if (bus_q == BUS_RD1) begin
            bus_d = BUS_RD2;  // Memory word being fetched
        end else begin
            bus_d    = BUS_IDLE;
            pend_d   = 1'b0;
            hready_d = 1'b1;
            if (req_q.ram) begin
                hrdata_d = ram_rdata;
            end else begin
                unique case (req_q.addr)
                    OFS_MODE:  hrdata_d = {24'h0, mode_q};
                    OFS_CTRL:  hrdata_d = {24'h0, ctrl_q};
                    OFS_CTL2:  hrdata_d = {24'h0, wave_q, CTL2_ONES, CTL2_ZERO, cds_q};
                    OFS_CKSTP: hrdata_d = {24'h0, CKSTP_ONES, ckstp_q};
                    OFS_STAT:  hrdata_d = {24'h0, 1'b0, m_q, com_q, pulse_hi, running, split_conn, supply_on};
                    default:   hrdata_d = 32'h0;  // Unmapped reads as zero
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q     <= BUS_IDLE;
            req_q     <= '0;
            pend_q    <= 1'b0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            bus_q     <= bus_d;
            req_q     <= req_d;
            pend_q    <= pend_d;
            hrdata    <= hrdata_d;
            hreadyout <= hready_d;
            hresp     <= 1'b0;  // Always OKAY
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_comb begin
        mode_d  = mode_q;
        ctrl_d  = ctrl_q;
        wave_d  = wave_q;
        cds_d   = cds_q;
        ckstp_d = ckstp_q;
        if (wr_commit && !req_q.ram && req_q.be[0]) begin
            unique case (req_q.addr)
                OFS_MODE:  mode_d  = lcddc_mode_s'(hwdata[7:0]);
                OFS_CTRL:  ctrl_d  = {1'b1, hwdata[6:0]};
                OFS_CTL2: begin
                    wave_d = hwdata[7];
                    cds_d  = hwdata[3:0];  // Bits 6 to 4 not stored
                end
                OFS_CKSTP: ckstp_d = hwdata[3:0];
                default:   ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q  <= lcddc_mode_s'(RST_MODE);
            ctrl_q  <= lcddc_ctrl_s'(RST_CTRL);
            wave_q  <= RST_CTL2[7];
            cds_q   <= RST_CTL2[3:0];
            ckstp_q <= RST_CKSTP[3:0];
        end else if (ce) begin
            mode_q  <= mode_d;
            ctrl_q  <= ctrl_d;
            wave_q  <= wave_d;
            cds_q   <= cds_d;
            ckstp_q <= ckstp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display memory; scan row chosen by common and expansion bank
    lcddc_ram #(
        .AW (3),
        .DW (32)
    ) u_ram (
        .clk       (hclk),
        .rst_n     (hresetn),
        .ce        (ce),
        .a_we      (ram_we),
        .a_addr    (req_q.addr[4:2]),
        .a_wdata   (hwdata),
        .a_rdata_q (ram_rdata),
        .b_addr    ({mode_q.segment_expand, com_q}),
        .b_rdata_q (row_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Operating clock divider and common scan
    assign running = ctrl_q.display_activate && ckstp_q[0];
    assign shift   = ctrl_q.frame_clock_field[3] ? {1'b0, ctrl_q.frame_clock_field[2:0]} + 4'h1
                   : 4'(W_SHIFT) + (ctrl_q.frame_clock_field[1] ? 4'h2 : {3'h0, ctrl_q.frame_clock_field[0]});
    assign limit   = 9'((9'h1 << shift) - 9'h1);
    assign tick    = running && div_q == limit;
    assign last    = com_q == mode_q.duty;

    always_comb begin
        div_d = (tick || !running) ? 9'h0 : 9'(div_q + 9'h1);
        com_d = com_q;
        m_d   = m_q;
        if (!running) begin
            com_d = 2'h0;
            m_d   = 1'b0;
        end else if (tick) begin
            if (!wave_q) begin
                // A waveform: phase flips inside every common slot
                m_d = !m_q;
                if (m_q) begin
                    com_d = last ? 2'h0 : 2'(com_q + 2'h1);
                end
            end else begin
                // B waveform: phase flips once per frame
                com_d = last ? 2'h0 : 2'(com_q + 2'h1);
                if (last) begin
                    m_d = !m_q;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 9'h0;
            com_q <= 2'h0;
            m_q   <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            com_q <= com_d;
            m_q   <= m_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charge/discharge pulse, stepped by the operating clock
    always_comb begin
        per = PER_EIGHT;
        chg = {2'h0, cds_q[2:0]};
        if (cds_q[3]) begin
            per = cds_q[2] ? PER_THIRT : PER_SIXT;
            chg = CHG_ONE;
        end
        pulse_hi = (cds_q == CDS_HIGH) ? 1'b1 : (cds_q == CDS_LOW) ? 1'b0 : pcnt_q < chg;
        // Rewrite restarts the period so a new duty starts clean
        if (ctl2_wr || !running) begin
            pcnt_d = 5'h0;
        end else if (tick) begin
            pcnt_d = (pcnt_q >= per) ? 5'h0 : 5'(pcnt_q + 5'h1);
        end else begin
            pcnt_d = pcnt_q;
        end
        supply_d = running && ctrl_q.drive_supply_switch;
        split_d  = supply_d && pulse_hi;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcnt_q     <= 5'h0;
            supply_on  <= 1'b0;
            split_conn <= 1'b0;
        end else if (ce) begin
            pcnt_q     <= pcnt_d;
            supply_on  <= supply_d;
            split_conn <= split_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Common levels, with boost sharing in static and half duty
    for (genvar k = 0; k < 4; k++) begin : g_com
        always_comb begin
            logic [1:0] lk;
            lk = 2'(k);
            if (mode_q.common_boost && mode_q.duty == DUTY_STATIC) begin
                lk = 2'h0;
            end else if (mode_q.common_boost && mode_q.duty == DUTY_HALF) begin
                lk = 2'(k / 2);
            end
            if (!running) begin
                com_d_lvl[k] = LVL_VSS;
            end else if (lk == com_q) begin
                com_d_lvl[k] = m_q ? LVL_VSS : LVL_V1;
            end else if (mode_q.duty == DUTY_HALF || mode_q.duty == DUTY_STATIC) begin
                com_d_lvl[k] = LVL_V2;  // Mid level on strapped V2/V3
            end else begin
                com_d_lvl[k] = m_q ? LVL_V2 : LVL_V3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment levels and driver enables
    for (genvar s = 0; s < NSEG; s++) begin : g_seg
        always_comb begin
            logic on;
            on = ctrl_q.display_data_control && row_q[s];
            if (!running) begin
                seg_d_lvl[s] = LVL_VSS;
            end else if (on) begin
                seg_d_lvl[s] = m_q ? LVL_V1 : LVL_VSS;
            end else if (mode_q.duty == DUTY_HALF || mode_q.duty == DUTY_STATIC) begin
                seg_d_lvl[s] = m_q ? LVL_VSS : LVL_V1;
            end else begin
                seg_d_lvl[s] = m_q ? LVL_V3 : LVL_V2;
            end
            // Groups of a quarter of the outputs, enabled in order
            seg_oe_d[s] = !mode_q.segment_expand
                        && mode_q.segment_select_field > 4'(s / (NSEG / 4));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            com_lvl <= '0;
            seg_lvl <= '0;
            seg_oe  <= '0;
        end else if (ce) begin
            com_lvl <= com_d_lvl;
            seg_lvl <= seg_d_lvl;
            seg_oe  <= seg_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic ctl2_touched_q;  // Helper: lcd_control_two written since reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl2_touched_q <= 1'b0;
        end else if (ce && ctl2_wr) begin
            ctl2_touched_q <= 1'b1;
        end
    end

    a_ctl2_fixed_bits: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && bus_q == BUS_RD2 && !req_q.ram && req_q.addr == OFS_CTL2 |=> hrdata[6:4] == 3'b110)
        else $error("fixed bits of control two read wrong");
    a_ctl2_reset_val: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctl2_touched_q |-> {wave_q, cds_q} == {RST_CTL2[7], RST_CTL2[3:0]})
        else $error("control two lost its reset value");
    a_wave_a_flip: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && tick && !wave_q |=> m_q != $past(m_q))
        else $error("A waveform phase did not flip");
    a_wave_b_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && tick && wave_q && !last |=> $stable(m_q) ##1 (!ce || m_q == $past(m_q, 2)))
        else $error("B waveform phase flipped mid frame");
    a_pulse_never: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && cds_q == CDS_LOW |=> !split_conn)
        else $error("resistance connected under zero duty");
    a_pulse_always: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && cds_q == CDS_HIGH && running && ctrl_q.drive_supply_switch |=> split_conn)
        else $error("constant high pulse missing");
    a_standby_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !ckstp_q[0] |=> !supply_on && com_lvl == '0)
        else $error("standby did not stop the drive");
    a_halt_supply: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !ctrl_q.display_activate |=> !supply_on && !split_conn)
        else $error("supply on while halted");
    a_boost_static: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && mode_q.common_boost && mode_q.duty == DUTY_STATIC |=> com_lvl[0] == com_lvl[3])
        else $error("boosted static commons differ");
    a_expand_oe: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && mode_q.segment_expand |=> seg_oe == '0)
        else $error("segment drivers on under expansion");
    a_pulse_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && ctl2_wr |=> pcnt_q == 5'h0)
        else $error("pulse did not restart on rewrite");

    c_frame_b: cover property (@(posedge hclk) disable iff (!hresetn) ce && tick && wave_q && last);
    c_ram_read: cover property (@(posedge hclk) disable iff (!hresetn) ce && bus_q == BUS_RD2 && req_q.ram);
    c_split_rise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(split_conn));

endmodule

// ---- src/lcddc_pkg.sv ----
// Shared constants, field layouts and types of the segment LCD drive control block
package lcddc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets (low byte of haddr)
    localparam logic [7:0] OFS_MODE  = 8'h00;  // Duty, boost, expansion, segment select
    localparam logic [7:0] OFS_CTRL  = 8'h04;  // Supply switch, activate, data control, frame clock
    localparam logic [7:0] OFS_CTL2  = 8'h08;  // lcd_control_two
    localparam logic [7:0] OFS_CKSTP = 8'h0c;  // clock_stop_two
    localparam logic [7:0] OFS_STAT  = 8'h10;  // Live drive state, read only
    localparam logic [2:0] RAM_SEL   = 3'h1;   // haddr[7:5] of the display memory window 0x20..0x3f

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h80;
    localparam logic [7:0] RST_CTL2  = 8'h60;
    localparam logic [7:0] RST_CKSTP = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // Fixed bit values of lcd_control_two and clock_stop_two
    localparam logic [1:0] CTL2_ONES  = 2'h3;  // Bits 6 and 5
    localparam logic       CTL2_ZERO  = 1'b0;  // Bit 4
    localparam logic [3:0] CKSTP_ONES = 4'hf;  // Bits 7 to 4

    ////////////////////////////////////////////////////////////////////////////
    // Charge/discharge pulse codes and periods (period minus one, in frame ticks)
    localparam logic [3:0] CDS_HIGH  = 4'h0;   // Constant connection
    localparam logic [3:0] CDS_LOW   = 4'h7;   // Never connected
    localparam logic [4:0] PER_EIGHT = 5'h07;
    localparam logic [4:0] PER_SIXT  = 5'h0f;
    localparam logic [4:0] PER_THIRT = 5'h1f;
    localparam logic [4:0] CHG_ONE   = 5'h01;  // Charge length of the 1/16 and 1/32 codes

    ////////////////////////////////////////////////////////////////////////////
    // Drive level codes on the common and segment outputs
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V3  = 2'h1;
    localparam logic [1:0] LVL_V2  = 2'h2;
    localparam logic [1:0] LVL_V1  = 2'h3;

    // AHB-Lite constants
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} lcddc_duty_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_RD1, BUS_RD2} lcddc_bus_e;

    typedef struct packed {
        lcddc_duty_e duty;       // Bits 7:6
        logic        common_boost;
        logic        segment_expand;
        logic [3:0]  segment_select_field;
    } lcddc_mode_s;

    typedef struct packed {
        logic        rsv_one;
        logic        drive_supply_switch;
        logic        display_activate;
        logic        display_data_control;
        logic [3:0]  frame_clock_field;
    } lcddc_ctrl_s;

    typedef struct packed {
        logic        wr;         // Write transfer
        logic        ram;        // Targets display memory
        logic [7:0]  addr;       // Byte offset
        logic [3:0]  be;         // Byte lanes
    } lcddc_req_s;

endpackage

// ---- src/lcddc_ram.sv ----
// Display memory with one bus port and one scan read port, both with registered read data
`timescale 1ns/100ps
module lcddc_ram #(
    parameter int AW = 3,
    parameter int DW = 32
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [DW/8-1:0]   a_we,
    input  wire logic [AW-1:0]     a_addr,
    input  wire logic [DW-1:0]     a_wdata,
    output logic      [DW-1:0]     a_rdata_q,
    input  wire logic [AW-1:0]     b_addr,
    output logic      [DW-1:0]     b_rdata_q
);

    ////////////////////////////////////////////////////////////////////////////
    // One storage array per byte lane, so that each array has a single writing process
    for (genvar g = 0; g < DW/8; g++) begin : g_lane
        logic [7:0] mem [2**AW];  // Storage, no reset: contents are software's

        // Byte lane write
        always_ff @(posedge clk) begin
            if (ce && a_we[g]) begin
                mem[a_addr] <= a_wdata[g*8 +: 8];
            end
        end

        // Registered reads on both ports, this lane's byte only
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                a_rdata_q[g*8 +: 8] <= 8'h0;
                b_rdata_q[g*8 +: 8] <= 8'h0;
            end else if (ce) begin
                a_rdata_q[g*8 +: 8] <= mem[a_addr];
                b_rdata_q[g*8 +: 8] <= mem[b_addr];
            end
        end
    end

endmodule

// ---- test/lcddc_panel.sv ----
// Segment LCD panel model: watches common and segment lines
`timescale 1ns/100ps
module lcddc_panel #(
    parameter int NSEG = 32  // Segment lines on the glass
) (
    input  wire logic [3:0][1:0]      com_lvl,
    input  wire logic [NSEG-1:0][1:0] seg_lvl,
    input  wire logic                 supply_on,
    output logic                      dark
);
    ////////////////////////////////////////////////////////////////////////////
    // Glass stays dark only while every line sits at the ground level and supply is off
    always_comb begin
        dark = (com_lvl === '0) && (seg_lvl === '0) && (supply_on === 1'b0);
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench of the LCD drive control block over AHB-Lite
`timescale 1ns/100ps
module tb;
    import lcddc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, split_conn, supply_on, dark;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0][1:0]  com_lvl;
    logic [31:0][1:0] seg_lvl;
    logic [31:0]      seg_oe;
    int err_count, checked, cnt, c;
    lcddc_top #(.NSEG(32), .W_SHIFT(0)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .com_lvl(com_lvl), .seg_lvl(seg_lvl),
        .seg_oe(seg_oe), .split_conn(split_conn), .supply_on(supply_on));
    lcddc_panel #(.NSEG(32)) panel (.com_lvl(com_lvl), .seg_lvl(seg_lvl), .supply_on(supply_on), .dark(dark));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and a hang guard sized well above the pulse sweep
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    // One single transfer; caller enters right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
        haddr  <= a;
        hwrite <= wr;
        hsize  <= sz;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, 3'h2, d);
    endtask
    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 3'h2, 32'h0);
    endtask
    // Charge cycles expected in 640 clocks, tick every 2 clocks
    function automatic int hi_count(input int code);
        if (code == 0) return 640;
        if (code == 7) return 0;
        if (code < 7) return code * 80;
        return (code < 12) ? 40 : 20;
    endfunction
    // Level changes seen on the first common over 16 clocks
    task automatic com0_changes();
        logic [1:0] pv;
        pv  = com_lvl[0];
        cnt = 0;
        repeat (16) begin
            @(posedge hclk);
            cnt += (com_lvl[0] !== pv);
            pv = com_lvl[0];
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_CTL2);   chk(r, 32'h60);
        rd(OFS_CKSTP);  chk(r, 32'hff);
        rd(32'h14);     chk(r, 32'h0);
        chk(hresp, 1'b0);
        wr(OFS_CTL2, 32'h8f);
        rd(OFS_CTL2);   chk(r, 32'hef);
        chk(r[7], 1'b1);
        chk(r[4], 1'b0);
        wr(OFS_CTL2, 32'h00);
        rd(OFS_CTL2);   chk(r, 32'h60);
        wr(32'h20, 32'h11223344);
        bus(1'b1, 32'h21, HSIZE_BYTE, 32'h0000aa00);
        rd(32'h20);     chk(r, 32'h1122aa44);
        wr(OFS_MODE, 32'h22);
        wr(OFS_CTRL, 32'h78);
        repeat (6) @(posedge hclk);
        chk(seg_oe, 32'h0000ffff);
        repeat (12) begin
            @(posedge hclk);
            chk({com_lvl[1], com_lvl[2], com_lvl[3]}, {3{com_lvl[0]}});
        end
        wr(OFS_MODE, 32'h62);
        repeat (4) @(posedge hclk);
        repeat (12) begin
            @(posedge hclk);
            chk({com_lvl[1], com_lvl[3]}, {com_lvl[0], com_lvl[2]});
        end
        // Half duty: A gives 3 level changes per 8 clocks, B gives 4
        com0_changes();
        chk(cnt, 6);
        wr(OFS_CTL2, 32'h80);
        repeat (8) @(posedge hclk);
        com0_changes();
        chk(cnt, 8);
        for (c = 0; c < 16; c++) begin
            wr(OFS_CTL2, c);
            repeat (8) @(posedge hclk);
            cnt = 0;
            repeat (640) begin
                @(posedge hclk);
                cnt += (split_conn === 1'b1);
            end
            chk(cnt, hi_count(c));
        end
        // Third and quarter duty: the fourth common is selected only in quarter duty
        for (c = 2; c < 4; c++) begin
            wr(OFS_MODE, {c[1:0], 6'h02});
            repeat (16) @(posedge hclk);
            cnt = 0;
            repeat (48) begin
                @(posedge hclk);
                cnt += (com_lvl[3][1] == com_lvl[3][0]);
            end
            chk(cnt, (c == 3) ? 12 : 0);
        end
        // Static duty, row 0: segment 2 holds a one, segment 0 a zero
        wr(OFS_MODE, 32'h02);
        repeat (16) @(posedge hclk);
        chk(seg_lvl[2] ^ seg_lvl[0], 2'h3);
        wr(OFS_CTRL, 32'h68);
        repeat (6) @(posedge hclk);
        chk(seg_lvl[2] ^ seg_lvl[0], 2'h0);
        wr(OFS_CKSTP, 32'hfe);
        repeat (4) @(posedge hclk);
        chk({supply_on, split_conn, dark}, 3'h1);
        rd(OFS_CKSTP);  chk(r, 32'hfe);
        wr(OFS_CKSTP, 32'hff);
        repeat (4) @(posedge hclk);
        chk(supply_on, 1'b1);
        wr(OFS_CTRL, 32'h58);
        repeat (4) @(posedge hclk);
        chk({supply_on, dark}, 2'h1);
        rd(OFS_CTRL);   chk(r, 32'hd8);
        rd(OFS_CTL2);   chk(r, 32'h6f);
        complete_run();
    end
endmodule
